// ==== hdl/sync_meter.v ====
`timescale 1ns/1ns
module sync_meter (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        sync_raw,
  output reg         active_high_r,
  output reg         start_r,
  output reg  [19:0] period_r
);
  reg        sync_d_r;
  reg [19:0] run_r;
  reg [19:0] hi_len_r;
  reg [19:0] lo_len_r;
  reg [19:0] per_cnt_r;
  wire       edge_w  = sync_raw != sync_d_r;
  wire       lead_w  = edge_w && (sync_raw == active_high_r);

  // ****************************************
  // Polarity: the shorter level is the pulse
  // ****************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_d_r      <= 1'b0;
      run_r         <= 20'h00000;
      hi_len_r      <= 20'hFFFFF;
      lo_len_r      <= 20'hFFFFF;
      active_high_r <= 1'b0;
      start_r       <= 1'b0;
      per_cnt_r     <= 20'h00000;
      period_r      <= 20'h00000;
    end
    else
    begin
      sync_d_r <= sync_raw;
      if (edge_w)
      begin
        run_r <= 20'h00001;
        if (sync_d_r)
          hi_len_r <= run_r;
        else
          lo_len_r <= run_r;
      end
      else if (run_r != 20'hFFFFF)
        run_r <= run_r + 20'h00001;
      active_high_r <= hi_len_r < lo_len_r;
      start_r <= lead_w;
      if (lead_w)
      begin
        period_r  <= per_cnt_r;
        per_cnt_r <= 20'h00001;
      end
      else if (per_cnt_r != 20'hFFFFF)
        per_cnt_r <= per_cnt_r + 20'h00001;
    end
  end
endmodule

// ==== hdl/video_input_mode_config.v ====
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "video_mode_consts.vh"
module video_input_mode_config (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        touch_port_select_switch,
  input  wire        menu_hide_switch,
  input  wire        video_source_switch,
  input  wire        reserved_switch_a,
  input  wire        reserved_switch_b,
  input  wire        reserved_switch_c,
  input  wire        reserved_switch_d,
  input  wire        reserved_switch_e,
  input  wire        analog_hsync,
  input  wire        analog_vsync,
  input  wire        dvi_hsync,
  input  wire        dvi_vsync,
  output wire        use_usb,
  output wire        on_screen_menu_enable,
  output wire        use_dvi,
  output wire        reserved_fault,
  output wire        analog_adjust_active,
  output wire        mode_valid,
  output wire [3:0]  mode_code,
  output wire [9:0]  h_scale,
  output wire [9:0]  v_scale,
  output wire [16:0] dot_khz,
  output wire [7:0]  contrast,
  output wire [7:0]  black_level,
  output wire [7:0]  h_position,
  output wire [7:0]  v_position,
  output wire [7:0]  menu_position_adjust,
  output wire [7:0]  sample_phase,
  output wire [7:0]  backlight
);
  reg         boot_done_r;
  reg  [7:0]  sw_r;
  reg  [11:0] line_cnt_r;
  reg  [11:0] lpf_r;
  reg         frame_r;
  reg  [3:0]  code_r;
  reg  [9:0]  hs_r;
  reg  [9:0]  vs_r;
  reg  [16:0] dot_r;
  reg         sel720_r;
  reg  [7:0]  contrast_r;
  reg  [7:0]  black_r;
  reg  [7:0]  hpos_r;
  reg  [7:0]  vpos_r;
  reg  [7:0]  mpos_r;
  reg  [7:0]  phase_r;
  reg  [7:0]  blt_r;
  reg  [7:0]  addr_r;
  reg         wr_pend_r;
  reg  [31:0] rd_nxt;
  wire        hpol;
  wire        vpol;
  wire        hstart;
  wire        vstart;
  wire [19:0] hper;
  wire [11:0] hper12  = (|hper[19:12]) ? 12'hFFF : hper[11:0];
  wire        analog  = !sw_r[2];
  wire        acc     = hsel && hready && htrans[1];
  wire        hs_sel  = sw_r[2] ? dvi_hsync : analog_hsync;
  wire        vs_sel  = sw_r[2] ? dvi_vsync : analog_vsync;
  wire [3:0]  cls     = classify(hper12, lpf_r, sel720_r);
  wire [31:0] dot_all = mode_ref(cls, 2'h2);

  // ****************************************
  // Table lookup and matching
  // ****************************************
  function [31:0] mode_ref;
    input [3:0] code;
    input [1:0] sel;
    reg   [95:0] row;
    begin
      case (code)
        4'h1: row = {`HZ_1, `VMHZ_1, `DOTK_1};
        4'h2: row = {`HZ_2, `VMHZ_2, `DOTK_2};
        4'h3: row = {`HZ_3, `VMHZ_3, `DOTK_3};
        4'h4: row = {`HZ_4, `VMHZ_4, `DOTK_4};
        4'h5: row = {`HZ_5, `VMHZ_5, `DOTK_5};
        4'h6: row = {`HZ_6, `VMHZ_6, `DOTK_6};
        4'h7: row = {`HZ_7, `VMHZ_7, `DOTK_7};
        4'h8: row = {`HZ_8, `VMHZ_8, `DOTK_8};
        4'h9: row = {`HZ_9, `VMHZ_9, `DOTK_9};
        4'hA: row = {`HZ_10, `VMHZ_10, `DOTK_10};
        4'hB: row = {`HZ_11, `VMHZ_11, `DOTK_11};
        default: row = {32'h00000001, 32'h00000001, 32'h00000000};
      endcase
      mode_ref = (sel == 2'h0) ? row[95:64] : (sel == 2'h1) ? row[63:32] : row[31:0];
    end
  endfunction

  function near;
    input [31:0] a;
    input [31:0] b;
    input [31:0] tol;
    begin
      near = ((a > b) ? (a - b) : (b - a)) <= tol;
    end
  endfunction

  // Dot clock is too fast to count here; line and frame rates pick the row
  function [3:0] classify;
    input [11:0] lp;
    input [11:0] lf;
    input        s720;
    integer      i;
    reg   [31:0] h;
    reg   [3:0]  c;
    begin
      classify = 4'h0;
      for (i = 1; i < 12; i = i + 1)
      begin
        c = i[3:0];
        h = mode_ref(c, 2'h0);
        if (near({20'h00000, lp}, `CLK_HZ / h, `LINE_TOL) &&
            near({20'h00000, lf}, h * 1000 / mode_ref(c, 2'h1), `LPF_TOL) &&
            !(c == `MODE_720X400_70 && !s720) &&
            !(c == `MODE_640X400_70 && s720))
          classify = c;
      end
    end
  endfunction

  // ****************************************
  // Boot-time switch capture
  // ****************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      boot_done_r <= 1'b0;
      sw_r        <= 8'h00;
    end
    else if (!boot_done_r)
    begin
      boot_done_r <= 1'b1;
      sw_r        <= {reserved_switch_e, reserved_switch_d, reserved_switch_c,
                      reserved_switch_b, reserved_switch_a, video_source_switch,
                      menu_hide_switch, touch_port_select_switch};
    end
  end

  assign use_usb               = sw_r[0];
  assign on_screen_menu_enable = !sw_r[1];
  assign use_dvi               = sw_r[2];
  assign reserved_fault        = |sw_r[7:3];
  assign analog_adjust_active  = analog;

  // ****************************************
  // Sync measurement and mode recognition
  // ****************************************
  sync_meter u_hmeter (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .sync_raw      (hs_sel),
    .active_high_r (hpol),
    .start_r       (hstart),
    .period_r      (hper)
  );

  sync_meter u_vmeter (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .sync_raw      (vs_sel),
    .active_high_r (vpol),
    .start_r       (vstart),
    .period_r      ()
  );

  // Progressive only: an interlaced source alternates counts and never locks
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      line_cnt_r <= 12'h000;
      lpf_r      <= 12'h000;
      frame_r    <= 1'b0;
      code_r     <= 4'h0;
      hs_r       <= 10'h000;
      vs_r       <= 10'h000;
      dot_r      <= 17'h00000;
    end
    else
    begin
      frame_r <= vstart;
      if (vstart)
      begin
        lpf_r      <= line_cnt_r;
        line_cnt_r <= {11'h000, hstart};
      end
      else if (hstart && line_cnt_r != 12'hFFF)
        line_cnt_r <= line_cnt_r + 12'h001;
      if (frame_r)
      begin
        code_r <= cls;
        dot_r  <= dot_all[16:0];
        case (cls)
          4'h1, 4'h2:
          begin
            hs_r <= `SC_1_6;
            vs_r <= `SC_1_92;
          end
          4'h3, 4'h4, 4'h5:
          begin
            hs_r <= `SC_1_6;
            vs_r <= `SC_1_6;
          end
          4'h6:
          begin
            hs_r <= `SC_1_42;
            vs_r <= `SC_1_92;
          end
          4'h7:
          begin
            hs_r <= `SC_1_28;
            vs_r <= `SC_1_28;
          end
          4'h8:
          begin
            hs_r <= `SC_1_2;
            vs_r <= `SC_1_2;
          end
          4'h9, 4'hA, 4'hB:
          begin
            hs_r <= `SC_1_0;
            vs_r <= `SC_1_0;
          end
          default:
          begin
            hs_r <= 10'h000;
            vs_r <= 10'h000;
          end
        endcase
      end
    end
  end

  assign mode_valid = code_r != 4'h0;
  assign mode_code  = code_r;
  assign h_scale    = hs_r;
  assign v_scale    = vs_r;
  assign dot_khz    = dot_r;

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @*
  begin
    rd_nxt = 32'h00000000;
    if (haddr[31:8] == 24'h000000)
      case (haddr[7:0])
        `REG_SWITCH: rd_nxt = {23'h000000, reserved_fault, sw_r};
        `REG_CTRL:   rd_nxt = {31'h00000000, sel720_r};
        `REG_MODE:   rd_nxt = {25'h0000000, vpol, hpol, mode_valid, code_r};
        `REG_MEAS:   rd_nxt = {4'h0, lpf_r, 4'h0, hper12};
        `REG_SCALE:  rd_nxt = {6'h00, vs_r, 6'h00, hs_r};
        `REG_ADJ_A:  rd_nxt = {vpos_r, hpos_r, black_r, contrast_r};
        `REG_ADJ_B:  rd_nxt = {8'h00, blt_r, phase_r, mpos_r};
        default:     rd_nxt = 32'h00000000;
      endcase
  end

  // Writes to analog-only fields are dropped while DVI-D is the source, but a restore write still resets them
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata     <= 32'h00000000;
      addr_r     <= 8'h00;
      wr_pend_r  <= 1'b0;
      sel720_r   <= 1'b0;
      contrast_r <= `CONTRAST_RST;
      black_r    <= `BLACK_RST;
      hpos_r     <= `HPOS_RST;
      vpos_r     <= `VPOS_RST;
      mpos_r     <= `MENUPOS_RST;
      phase_r    <= `PHASE_RST;
      blt_r      <= `BACKLIGHT_RST;
    end
    else
    begin
      wr_pend_r <= acc && hwrite && (haddr[31:8] == 24'h000000);
      hrdata    <= (acc && !hwrite) ? rd_nxt : 32'h00000000;
      if (acc)
        addr_r <= haddr[7:0];
      if (wr_pend_r)
        case (addr_r)
          `REG_CTRL: sel720_r <= hwdata[`CTRL_SEL720_BIT];
          `REG_ADJ_A:
          begin
            if (analog)
            begin
              contrast_r <= hwdata[7:0];
              black_r    <= hwdata[15:8];
            end
            hpos_r <= hwdata[23:16];
            vpos_r <= hwdata[31:24];
          end
          `REG_ADJ_B:
            if (hwdata[`ADJ_B_RESTORE_BIT])
            begin
              contrast_r <= `CONTRAST_RST;
              black_r    <= `BLACK_RST;
              hpos_r     <= `HPOS_RST;
              vpos_r     <= `VPOS_RST;
              mpos_r     <= `MENUPOS_RST;
              phase_r    <= `PHASE_RST;
              blt_r      <= `BACKLIGHT_RST;
            end
            else
            begin
              if (analog)
              begin
                mpos_r  <= hwdata[7:0];
                phase_r <= hwdata[15:8];
              end
              blt_r <= hwdata[23:16];
            end
          default: sel720_r <= sel720_r;
        endcase
    end
  end

  assign contrast             = contrast_r;
  assign black_level          = black_r;
  assign h_position           = hpos_r;
  assign v_position           = vpos_r;
  assign menu_position_adjust = mpos_r;
  assign sample_phase         = phase_r;
  assign backlight            = blt_r;
endmodule

// ==== hdl/video_mode_consts.vh ====
`ifndef VIDEO_MODE_CONSTS_VH
`define VIDEO_MODE_CONSTS_VH
// What this block does
// - Touch-port switch off routes touch data to RS-232C; on routes it to USB.
// - Menu-hide switch on suppresses the on-screen menu; off lets it show.
// - Video-source switch on takes DVI-D input; off takes analog RGB input.
// - A switch change takes effect only after the next reboot.
// - Sync pulses of either polarity are accepted and the polarity is learnt.
// - Each mode is recognised from line rate and frame rate; its dot clock comes from the table.
// - Recognised modes are scaled to fill the 1024x768 panel, except mode 8, which is scaled by 1.2 only.
// - Rates shared by 640x400 and 720x400 mean 720x400 only when selected.
// - Analog input offers contrast, black, position, phase, backlight, restore.

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 32'h017D7840
`define LINE_TOL 32'h00000008
`define LPF_TOL 32'h00000004

// ****************************************
// Mode table: line rate Hz, frame rate mHz, dot clock kHz
// ****************************************
// Sized so that table rows can be concatenated
`define HZ_1 32'h000060FB
`define VMHZ_1 32'h0000DAC0
`define DOTK_1 32'h0000523D
`define HZ_2 32'h00007AED
`define VMHZ_2 32'h00011170
`define DOTK_2 32'h00006257
`define HZ_3 32'h00007AED
`define VMHZ_3 32'h0000EA58
`define DOTK_3 32'h00006257
`define HZ_4 32'h0000927C
`define VMHZ_4 32'h000124F8
`define DOTK_4 32'h00007B0C
`define HZ_5 32'h000088B8
`define VMHZ_5 32'h0001046B
`define DOTK_5 32'h00007620
`define HZ_6 32'h00007AED
`define VMHZ_6 32'h00011170
`define DOTK_6 32'h00006EA0
`define HZ_7 32'h000093F7
`define VMHZ_7 32'h0000EB9D
`define DOTK_7 32'h00009C40
`define HZ_8 32'h0000B71B
`define VMHZ_8 32'h000124F8
`define DOTK_8 32'h0000C15C
`define HZ_9 32'h0000BCEB
`define VMHZ_9 32'h0000EA64
`define DOTK_9 32'h0000FDE8
`define HZ_10 32'h0000DC9C
`define VMHZ_10 32'h000111B5
`define DOTK_10 32'h000124F8
`define HZ_11 32'h0000EA77
`define VMHZ_11 32'h00012515
`define DOTK_11 32'h0001339E
`define MODE_640X400_70 4'h2
`define MODE_720X400_70 4'h6

// ****************************************
// Scale factors, 2.8 fixed point
// ****************************************
`define SC_1_0 10'h100
`define SC_1_2 10'h133
`define SC_1_28 10'h148
`define SC_1_42 10'h16C
`define SC_1_6 10'h19A
`define SC_1_92 10'h1EC

// ****************************************
// Registers
// ****************************************
`define REG_SWITCH 8'h00
`define REG_CTRL 8'h04
`define REG_MODE 8'h08
`define REG_MEAS 8'h0C
`define REG_SCALE 8'h10
`define REG_ADJ_A 8'h14
`define REG_ADJ_B 8'h18
`define CTRL_SEL720_BIT 0
`define ADJ_B_RESTORE_BIT 31
`define CONTRAST_RST 8'h80
`define BLACK_RST 8'h80
`define HPOS_RST 8'h80
`define VPOS_RST 8'h80
`define MENUPOS_RST 8'h80
`define PHASE_RST 8'h10
`define BACKLIGHT_RST 8'hFF
`endif

// ==== tb/video_input_mode_config_assertions.sv ====
`timescale 1ns/1ns
`include "video_mode_consts.vh"
module mode_config_checker (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        use_usb,
  input wire        on_screen_menu_enable,
  input wire        use_dvi,
  input wire        reserved_fault,
  input wire        analog_adjust_active,
  input wire        mode_valid,
  input wire [3:0]  mode_code,
  input wire [9:0]  h_scale,
  input wire [9:0]  v_scale,
  input wire [16:0] dot_khz
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Two settled cycles, so the latching edge is never compared
  sequence s_settled;
    hresetn && $past(hresetn) && $past(hresetn, 2);
  endsequence
  sequence s_rd_sw;
    hsel && hready && htrans[1] && !hwrite && haddr == {24'h0, `REG_SWITCH};
  endsequence
  a_latch_held: assert property (s_settled |->
    $stable({use_usb, use_dvi, on_screen_menu_enable, reserved_fault}))
    else $error("latched switch output moved");
  a_adjust_analog: assert property (analog_adjust_active == !use_dvi)
    else $error("adjust flag not tied to analog source");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_valid_code: assert property (mode_valid == (mode_code != 4'h0))
    else $error("valid flag disagrees with code");
  a_idle_zero: assert property (!mode_valid |->
    h_scale == 10'h000 && v_scale == 10'h000 && dot_khz == 17'h00000)
    else $error("scale or dot clock set without mode");
  a_pass_xga: assert property (mode_code inside {4'h9, 4'hA, 4'hB} |->
    h_scale == `SC_1_0 && v_scale == `SC_1_0) else $error("xga mode scaled");
  a_scale_vga: assert property (mode_code inside {4'h3, 4'h4, 4'h5} |->
    h_scale == `SC_1_6 && v_scale == `SC_1_6) else $error("vga scale wrong");
  a_code_wide: assert property (mode_code == `MODE_720X400_70 |->
    h_scale == `SC_1_42 && v_scale == `SC_1_92 && dot_khz == `DOTK_6)
    else $error("wide text mode figures wrong");
  a_dot_xga: assert property (mode_code == 4'h9 |-> dot_khz == `DOTK_9)
    else $error("xga dot clock wrong");
  a_fault_read: assert property (s_rd_sw |=> hrdata[8] == $past(reserved_fault))
    else $error("fault bit readback wrong");
endmodule
bind video_input_mode_config mode_config_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .use_usb(use_usb),
  .on_screen_menu_enable(on_screen_menu_enable), .use_dvi(use_dvi),
  .reserved_fault(reserved_fault), .analog_adjust_active(analog_adjust_active),
  .mode_valid(mode_valid), .mode_code(mode_code), .h_scale(h_scale), .v_scale(v_scale),
  .dot_khz(dot_khz));

// ==== tb/video_input_mode_config_tb.sv ====
`timescale 1ns/1ns
`include "video_mode_consts.vh"
module video_input_mode_config_tb;
  // ****************************************
  // Signals
  // ****************************************
  reg         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, run = 0, pol_h = 0, pol_v = 0;
  reg  [31:0] haddr = 0, hwdata = 0, rd = 0;
  reg  [1:0]  htrans = 0;
  reg  [2:0]  hsize = 3'h2;
  reg  [7:0]  sw = 0;
  reg  [11:0] line_len = 12'd100, lines = 12'd20;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, use_usb, menu_en, use_dvi, rsv_flt, adj_act, mode_valid, hs, vs;
  wire [3:0]  mode_code;
  wire [9:0]  h_scale, v_scale;
  wire [16:0] dot_khz;
  wire [7:0]  con, blk, hpos, vpos, mpos, phs, bkl;
  integer     error_cnt = 0, checked = 0, i;
  always #20 hclk = ~hclk;
  video_sync_model u_src (.hclk(hclk), .run(run), .line_len(line_len), .lines(lines),
    .pol_h(pol_h), .pol_v(pol_v), .hs(hs), .vs(vs));
  video_input_mode_config u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .touch_port_select_switch(sw[0]),
    .menu_hide_switch(sw[1]), .video_source_switch(sw[2]), .reserved_switch_a(sw[3]),
    .reserved_switch_b(sw[4]), .reserved_switch_c(sw[5]), .reserved_switch_d(sw[6]),
    .reserved_switch_e(sw[7]), .analog_hsync(hs), .analog_vsync(vs), .dvi_hsync(hs),
    .dvi_vsync(vs), .use_usb(use_usb), .on_screen_menu_enable(menu_en), .use_dvi(use_dvi),
    .reserved_fault(rsv_flt), .analog_adjust_active(adj_act), .mode_valid(mode_valid),
    .mode_code(mode_code), .h_scale(h_scale), .v_scale(v_scale), .dot_khz(dot_khz),
    .contrast(con), .black_level(blk), .h_position(hpos), .v_position(vpos),
    .menu_position_adjust(mpos), .sample_phase(phs), .backlight(bkl));
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input [95:0] nm, input logic [31:0] exp, input logic [31:0] got);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0s exp %h got %h", nm, exp, got);
    end
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task wait_rdy;
    integer n;
  begin
    n = 0;
    // Ready is judged at the edge itself, not a step later
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      if (n == 50)
      begin
        error_cnt = error_cnt + 1;
        end_sim;
      end
      n = n + 1;
      @(posedge hclk);
    end
  end
  endtask
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
  begin
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
    #1;
  end
  endtask
  task do_reset(input [7:0] s);
  begin
    @(posedge hclk);
    sw <= s;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
  end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_defaults;
  begin
    do_reset(8'h00);
    chk("usb", 0, use_usb);
    chk("menu_en", 1, menu_en);
    chk("dvi", 0, use_dvi);
    chk("adj_act", 1, adj_act);
    chk("adjust", {`CONTRAST_RST, `BLACK_RST, `HPOS_RST, `VPOS_RST}, {con, blk, hpos, vpos});
    chk("adjust2", {`MENUPOS_RST, `PHASE_RST, `BACKLIGHT_RST}, {mpos, phs, bkl});
    bus(0, `REG_SWITCH, 0);
    chk("sw_fault", 0, rd[8]);
    $display("test defaults done");
  end
  endtask
  task t_switches;
  begin
    do_reset(8'h07);
    chk("usb", 1, use_usb);
    chk("menu_en", 0, menu_en);
    chk("dvi", 1, use_dvi);
    chk("adj_act", 0, adj_act);
    bus(1, `REG_ADJ_A, 32'h11223344);
    chk("con_dvi", `CONTRAST_RST, con);
    chk("pos_dvi", 16'h1122, {vpos, hpos});
    @(posedge hclk);
    sw <= 8'h00;
    repeat (10) @(posedge hclk);
    #1;
    chk("held", 3'b101, {use_usb, menu_en, use_dvi});
    do_reset(8'h00);
    chk("reboot", 3'b010, {use_usb, menu_en, use_dvi});
    $display("test switches done");
  end
  endtask
  task t_reserved;
  begin
    for (i = 3; i < 8; i = i + 1)
    begin
      do_reset(8'h01 << i);
      chk("fault", 1, rsv_flt);
      bus(0, `REG_SWITCH, 0);
      chk("sw_fault", 1, rd[8]);
    end
    do_reset(8'h00);
    $display("test reserved done");
  end
  endtask
  task t_regs;
  begin
    bus(1, `REG_CTRL, 1);
    bus(0, `REG_CTRL, 0);
    chk("ctrl", 1, rd[0]);
    bus(1, `REG_ADJ_A, 32'hA1B2C3D4);
    bus(0, `REG_ADJ_A, 0);
    chk("adj_a", 32'hA1B2C3D4, rd);
    chk("con", 8'hD4, con);
    bus(1, `REG_ADJ_B, 32'h00AA5566);
    bus(0, `REG_ADJ_B, 0);
    chk("adj_b", 32'h00AA5566, rd);
    bus(1, `REG_ADJ_B, 32'h80000000);
    bus(0, `REG_ADJ_A, 0);
    chk("restore", {`VPOS_RST, `HPOS_RST, `BLACK_RST, `CONTRAST_RST}, rd);
    chk("bkl", `BACKLIGHT_RST, bkl);
    bus(0, 32'h00000040, 0);
    chk("unmapped", 0, rd);
    chk("resp", 0, hresp);
    bus(1, `REG_MODE, 32'h0000FFFF);
    bus(0, `REG_MODE, 0);
    chk("mode_ro", 0, rd[3:0]);
    $display("test registers done");
  end
  endtask
  // Short frames only: real modes need far longer frames than this run allows
  task t_sync;
  begin
    for (i = 0; i < 2; i = i + 1)
    begin
      @(posedge hclk);
      pol_h <= i[0];
      pol_v <= i[0];
      run <= 1'b1;
      // Four frames: polarity is relearnt before the last count is taken
      repeat (8000) @(posedge hclk);
      #1;
      bus(0, `REG_MODE, 0);
      chk("polarity", {i[0], i[0]}, rd[6:5]);
      chk("code", 0, mode_code);
      chk("scale", 0, {h_scale, v_scale});
      chk("dot", 0, {mode_valid, dot_khz});
      bus(0, `REG_MEAS, 0);
      chk("meas", {4'h0, lines, 4'h0, line_len}, rd);
      run <= 1'b0;
    end
    $display("test sync done");
  end
  endtask
  initial
  begin
    t_defaults;
    t_switches;
    t_reserved;
    t_regs;
    t_sync;
    end_sim;
  end
endmodule

// ==== tb/video_sync_model.sv ====
`timescale 1ns/1ns
module video_sync_model (
  input  wire        hclk,
  input  wire        run,
  input  wire [11:0] line_len,
  input  wire [11:0] lines,
  input  wire        pol_h,
  input  wire        pol_v,
  output reg         hs,
  output reg         vs
);
  // ****************************************
  // Source timing
  // ****************************************
  integer px = 0;
  integer ln = 0;
  initial hs = 1'b0;
  initial vs = 1'b0;
  always @(posedge hclk)
  begin
    if (!run)
    begin
      px <= 0;
      ln <= 0;
      hs <= !pol_h;
      vs <= !pol_v;
    end
    else
    begin
      px <= (px == line_len - 1) ? 0 : px + 1;
      if (px == line_len - 1)
        ln <= (ln == lines - 1) ? 0 : ln + 1;
      hs <= (px < 8) ? pol_h : !pol_h;
      // Whole lines only, no half-line field offset
      vs <= (ln < 2) ? pol_v : !pol_v;
    end
  end
endmodule
